// File: hdl/dual_input_fault_detect.sv
// Dual-function supervisory input: threshold detector, logic input, registers and interrupt.
// Assumes an AHB-Lite master on REF_CLK, a digitised level on SAMPLE in the same domain,
// and an asynchronous logic pin on LOGIC_PIN.
`include "fault_detect_consts.svh"
`default_nettype none
module dual_input_fault_detect #(
	parameter int GF_C5_CYC = `GF_C5,
	parameter int GF_C6_CYC = `GF_C6,
	parameter int GF_C7_CYC = `GF_C7,
	parameter int PULSE_C1_CYC = `PULSE_C1,
	parameter int PULSE_C2_CYC = `PULSE_C2,
	parameter int PULSE_C3_CYC = `PULSE_C3
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic [7:0] SAMPLE,
	input wire logic LOGIC_PIN,
	output logic FAULT_OUT,
	output logic WARNING_OUT,
	output logic OVER_LIMIT_FLAG,
	output logic UNDER_LIMIT_FLAG,
	output logic IRQ
);
	// One counter width serves both filters and the pulse stretcher.
	localparam int CW = `CNT_W;

	// Register file.
	logic [7:0] over_th_q, over_th_d, under_th_q, under_th_d;
	logic [`HY_W-1:0] over_hy_q, over_hy_d, under_hy_q, under_hy_d;
	logic [4:0] det_cfg_q, det_cfg_d;
	logic [1:0] func_sel_q, func_sel_d;
	logic [6:0] logic_cfg_q, logic_cfg_d;
	logic [`EV_W-1:0] status_q, status_d, mask_q, mask_d;

	// Bus state.
	logic wr_pend_q, wr_pend_d;
	logic [7:0] wr_idx_q, wr_idx_d;
	logic [31:0] rdata_d;
	logic addr_take, addr_ok, rd_take;
	logic [7:0] a_idx;

	// Detector and logic path state.
	logic over_d, under_d;
	logic [8:0] over_rel, under_rel;
	logic det_raw;
	logic [1:0] pin_sync_q;
	logic [1:0] filt_in;
	logic [1:0] filt_out;
	logic [CW-1:0] filt_lim [2];
	logic logic_prev_q, logic_prev_d;
	logic [CW-1:0] pulse_cnt_q, pulse_cnt_d;
	logic logic_act, logic_edge;
	logic fault_d, warn_d, irq_d;
	logic [`EV_W-1:0] ev;

	fault_detect_pkg::fault_type_t ftype;
	fault_detect_pkg::function_route_t froute;

	assign ftype = fault_detect_pkg::fault_type_t'(det_cfg_q[`DET_TYPE_LSB +: 2]);
	assign froute = fault_detect_pkg::function_route_t'(func_sel_q);

	// The long filter and pulse counts are parameters so that a bench can shorten them;
	// the short ones stay fixed because they already fit a short run.
	function automatic logic [CW-1:0] gf_limit(input logic [2:0] code);
		logic [CW-1:0] r;
		r = '0;
		case (code)
			3'h1: r = CW'(`GF_C1);
			3'h2: r = CW'(`GF_C2);
			3'h3: r = CW'(`GF_C3);
			3'h4: r = CW'(`GF_C4);
			3'h5: r = CW'(GF_C5_CYC);
			3'h6: r = CW'(GF_C6_CYC);
			3'h7: r = CW'(GF_C7_CYC);
			default: r = '0;
		endcase
		return r;
	endfunction

	function automatic logic [CW-1:0] pulse_limit(input logic [1:0] code);
		logic [CW-1:0] r;
		r = CW'(`PULSE_C0);
		case (code)
			2'h1: r = CW'(PULSE_C1_CYC);
			2'h2: r = CW'(PULSE_C2_CYC);
			2'h3: r = CW'(PULSE_C3_CYC);
			default: r = CW'(`PULSE_C0);
		endcase
		return r;
	endfunction

	// AHB-Lite address phase decode; transfers are single words with zero wait states.
	always_comb begin
		addr_take = HSEL && HREADY && HTRANS[1];
		addr_ok = (HADDR[31:10] == 22'h000000) && (HADDR[1:0] == 2'h0);
		a_idx = HADDR[9:2];
		rd_take = addr_take && !HWRITE && addr_ok;
	end

	// Read data is registered in the address phase so it stands through the data phase.
	always_comb begin
		rdata_d = HRDATA;
		if (rd_take) begin
			rdata_d = 32'h00000000;
			case (a_idx)
				`IDX_OVER_TH: rdata_d[7:0] = over_th_q;
				`IDX_OVER_HY: rdata_d[`HY_W-1:0] = over_hy_q;
				`IDX_UNDER_TH: rdata_d[7:0] = under_th_q;
				`IDX_UNDER_HY: rdata_d[`HY_W-1:0] = under_hy_q;
				`IDX_DET_CFG: rdata_d[4:0] = det_cfg_q;
				`IDX_FUNC_SEL: rdata_d[1:0] = func_sel_q;
				`IDX_LOGIC_CFG: rdata_d[6:0] = logic_cfg_q;
				`IDX_EVENT_STATUS: rdata_d[`EV_W-1:0] = status_q;
				`IDX_EVENT_MASK: rdata_d[`EV_W-1:0] = mask_q;
				default: rdata_d = 32'h00000000;
			endcase
			// Live flags sit above the sticky events and are not cleared by the read.
			if (a_idx == `IDX_EVENT_STATUS) begin
				rdata_d[8] = FAULT_OUT;
				rdata_d[9] = WARNING_OUT;
				rdata_d[10] = OVER_LIMIT_FLAG;
				rdata_d[11] = UNDER_LIMIT_FLAG;
			end
		end else if (addr_take && !HWRITE) begin
			// A misaligned or out-of-range read returns zero rather than stale data.
			rdata_d = 32'h00000000;
		end
	end

	// Register writes complete in the data phase with the captured index.
	always_comb begin
		wr_pend_d = addr_take && HWRITE && addr_ok;
		wr_idx_d = addr_take ? a_idx : wr_idx_q;
		over_th_d = over_th_q;
		over_hy_d = over_hy_q;
		under_th_d = under_th_q;
		under_hy_d = under_hy_q;
		det_cfg_d = det_cfg_q;
		func_sel_d = func_sel_q;
		logic_cfg_d = logic_cfg_q;
		mask_d = mask_q;
		// Upper unused bits are dropped; software must not rely on them.
		if (wr_pend_q) begin
			case (wr_idx_q)
				`IDX_OVER_TH: over_th_d = HWDATA[7:0];
				`IDX_OVER_HY: over_hy_d = HWDATA[`HY_W-1:0];
				`IDX_UNDER_TH: under_th_d = HWDATA[7:0];
				`IDX_UNDER_HY: under_hy_d = HWDATA[`HY_W-1:0];
				`IDX_DET_CFG: det_cfg_d = HWDATA[4:0];
				`IDX_FUNC_SEL: func_sel_d = HWDATA[1:0];
				`IDX_LOGIC_CFG: logic_cfg_d = HWDATA[6:0];
				`IDX_EVENT_MASK: mask_d = HWDATA[`EV_W-1:0];
				// The status index takes no writes; only a read clears it.
				default: mask_d = mask_q;
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 8'h00;
			HRDATA <= 32'h00000000;
			HREADYOUT <= 1'b0;
			HRESP <= 1'b0;
			over_th_q <= `RST_THRESHOLD;
			over_hy_q <= `RST_HYST;
			under_th_q <= `RST_THRESHOLD;
			under_hy_q <= `RST_HYST;
			det_cfg_q <= `RST_DET_CFG;
			func_sel_q <= `RST_FUNC_SEL;
			logic_cfg_q <= `RST_LOGIC_CFG;
			mask_q <= `RST_MASK;
		end else begin
			wr_pend_q <= wr_pend_d;
			wr_idx_q <= wr_idx_d;
			HRDATA <= rdata_d;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			over_th_q <= over_th_d;
			over_hy_q <= over_hy_d;
			under_th_q <= under_th_d;
			under_hy_q <= under_hy_d;
			det_cfg_q <= det_cfg_d;
			func_sel_q <= func_sel_d;
			logic_cfg_q <= logic_cfg_d;
			mask_q <= mask_d;
		end
	end

	// Threshold comparison with hysteresis, saturated at the ends of the 8-bit range.
	// The release level only applies while a flag is set, which gives the hysteresis.
	always_comb begin
		over_rel = (9'(over_hy_q) > 9'(over_th_q)) ? 9'h000 :
			9'(over_th_q) - 9'(over_hy_q);
		under_rel = 9'(under_th_q) + 9'(under_hy_q);
		if (under_rel > 9'h0FF) begin
			under_rel = 9'h0FF;
		end
		if (OVER_LIMIT_FLAG) begin
			over_d = 9'(SAMPLE) > over_rel;
		end else begin
			over_d = SAMPLE > over_th_q;
		end
		if (UNDER_LIMIT_FLAG) begin
			under_d = 9'(SAMPLE) < under_rel;
		end else begin
			under_d = SAMPLE < under_th_q;
		end
		case (ftype)
			fault_detect_pkg::FT_OVER_ONLY: det_raw = OVER_LIMIT_FLAG;
			fault_detect_pkg::FT_OVER_OR_UNDER: det_raw = OVER_LIMIT_FLAG | UNDER_LIMIT_FLAG;
			fault_detect_pkg::FT_UNDER_ONLY: det_raw = UNDER_LIMIT_FLAG;
			default: det_raw = 1'b0;
		endcase
	end

	// The pin is asynchronous; only the second stage feeds the logic path.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			pin_sync_q <= 2'h0;
		end else begin
			pin_sync_q <= {pin_sync_q[0], LOGIC_PIN};
		end
	end

	always_comb begin
		filt_in[0] = det_raw;
		filt_in[1] = pin_sync_q[1] ^ logic_cfg_q[`LOGIC_INV_BIT];
		filt_lim[0] = gf_limit(det_cfg_q[`DET_GF_LSB +: 3]);
		filt_lim[1] = gf_limit(logic_cfg_q[`LOGIC_GF_LSB +: 3]);
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_filt
			glitch_qualifier #(
				.CNT_W(CW)
			) u_filt (
				.clk(REF_CLK),
				.rst_n(RST_N),
				.din(filt_in[gi]),
				.lim(filt_lim[gi]),
				.dout(filt_out[gi])
			);
		end
	endgenerate

	// Logic input: level mode passes the qualified level; edge mode stretches each rising edge.
	always_comb begin
		// The previous level resets low like the filter, so no false edge follows reset.
		logic_prev_d = filt_out[1];
		logic_edge = filt_out[1] && !logic_prev_q;
		pulse_cnt_d = pulse_cnt_q;
		if (logic_edge) begin
			// A new edge during a pulse restarts the full length.
			pulse_cnt_d = pulse_limit(logic_cfg_q[`LOGIC_PULSE_LSB +: 2]);
		end else if (pulse_cnt_q != '0) begin
			pulse_cnt_d = pulse_cnt_q - 1'b1;
		end
		if (logic_cfg_q[`LOGIC_EDGE_BIT]) begin
			logic_act = pulse_cnt_q != '0;
		end else begin
			logic_act = filt_out[1];
		end
	end

	// Route selection onto the fault and warning flags.
	// Route code 11 leaves both flags low; the limit flags and the over, under and edge events still follow the input.
	always_comb begin
		fault_d = 1'b0;
		warn_d = 1'b0;
		case (froute)
			fault_detect_pkg::FN_DETECTOR_FAULT: fault_d = filt_out[0];
			fault_detect_pkg::FN_LOGIC_FAULT: fault_d = logic_act;
			fault_detect_pkg::FN_LOGIC_FAULT_DET_WARN: begin
				fault_d = logic_act;
				warn_d = filt_out[0];
			end
			default: fault_d = 1'b0;
		endcase
	end

	// Sticky events; a new event in the cycle of a clearing read is kept.
	// Events are rising edges of the four flags and of the qualified logic input, so a level that stays high raises one event.
	always_comb begin
		ev = '0;
		ev[`EV_FAULT_BIT] = fault_d && !FAULT_OUT;
		ev[`EV_WARN_BIT] = warn_d && !WARNING_OUT;
		ev[`EV_OVER_BIT] = over_d && !OVER_LIMIT_FLAG;
		ev[`EV_UNDER_BIT] = under_d && !UNDER_LIMIT_FLAG;
		ev[`EV_EDGE_BIT] = logic_edge;
		status_d = status_q;
		if (rd_take && a_idx == `IDX_EVENT_STATUS) begin
			status_d = '0;
		end
		status_d = status_d | ev;
		irq_d = |(status_d & mask_d);
	end

	// Every output is registered, so the sequencer never sees combinational glitches.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			OVER_LIMIT_FLAG <= 1'b0;
			UNDER_LIMIT_FLAG <= 1'b0;
			logic_prev_q <= 1'b0;
			pulse_cnt_q <= '0;
			FAULT_OUT <= 1'b0;
			WARNING_OUT <= 1'b0;
			status_q <= '0;
			IRQ <= 1'b0;
		end else begin
			OVER_LIMIT_FLAG <= over_d;
			UNDER_LIMIT_FLAG <= under_d;
			logic_prev_q <= logic_prev_d;
			pulse_cnt_q <= pulse_cnt_d;
			FAULT_OUT <= fault_d;
			WARNING_OUT <= warn_d;
			status_q <= status_d;
			IRQ <= irq_d;
		end
	end
endmodule
`default_nettype wire

// File: hdl/fault_detect_consts.svh
// Register indices, field positions, reset values and timing counts for the fault detector.
// Assumes a 100 MHz reference clock; byte address of a register is four times its index.
`ifndef FAULT_DETECT_CONSTS_SVH
`define FAULT_DETECT_CONSTS_SVH

`define IDX_OVER_TH 8'h30
`define IDX_OVER_HY 8'h31
`define IDX_UNDER_TH 8'h32
`define IDX_UNDER_HY 8'h33
`define IDX_DET_CFG 8'h34
`define IDX_FUNC_SEL 8'h35
`define IDX_LOGIC_CFG 8'h36
`define IDX_EVENT_STATUS 8'h37
`define IDX_EVENT_MASK 8'h3F

`define HY_W 5
`define DET_GF_LSB 2
`define DET_TYPE_LSB 0
`define LOGIC_INV_BIT 6
`define LOGIC_EDGE_BIT 5
`define LOGIC_PULSE_LSB 3
`define LOGIC_GF_LSB 0

`define RST_THRESHOLD 8'h00
`define RST_HYST 5'h00
`define RST_DET_CFG 5'h00
`define RST_FUNC_SEL 2'h0
`define RST_LOGIC_CFG 7'h00
`define RST_MASK 5'h00

`define EV_FAULT_BIT 0
`define EV_WARN_BIT 1
`define EV_OVER_BIT 2
`define EV_UNDER_BIT 3
`define EV_EDGE_BIT 4
`define EV_W 5

`define CLK_FREQ_MHZ 100
`define GF_T1_US 5
`define GF_T2_US 10
`define GF_T3_US 20
`define GF_T4_US 30
`define GF_T5_US 50
`define GF_T6_US 75
`define GF_T7_US 100
`define PULSE_T0_US 10
`define PULSE_T1_US 100
`define PULSE_T2_US 1000
`define PULSE_T3_US 10000
`define GF_C1 (`GF_T1_US * `CLK_FREQ_MHZ)
`define GF_C2 (`GF_T2_US * `CLK_FREQ_MHZ)
`define GF_C3 (`GF_T3_US * `CLK_FREQ_MHZ)
`define GF_C4 (`GF_T4_US * `CLK_FREQ_MHZ)
`define GF_C5 (`GF_T5_US * `CLK_FREQ_MHZ)
`define GF_C6 (`GF_T6_US * `CLK_FREQ_MHZ)
`define GF_C7 (`GF_T7_US * `CLK_FREQ_MHZ)
`define PULSE_C0 (`PULSE_T0_US * `CLK_FREQ_MHZ)
`define PULSE_C1 (`PULSE_T1_US * `CLK_FREQ_MHZ)
`define PULSE_C2 (`PULSE_T2_US * `CLK_FREQ_MHZ)
`define PULSE_C3 (`PULSE_T3_US * `CLK_FREQ_MHZ)
`define CNT_W 20

`endif

// File: hdl/fault_detect_pkg.sv
// Types shared by the fault detector files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package fault_detect_pkg;
	typedef enum logic [1:0] {
		FT_OVER_ONLY = 2'h0,
		FT_OVER_OR_UNDER = 2'h1,
		FT_UNDER_ONLY = 2'h2,
		FT_OFF = 2'h3
	} fault_type_t;
	typedef enum logic [1:0] {
		FN_DETECTOR_FAULT = 2'h0,
		FN_LOGIC_FAULT = 2'h1,
		FN_LOGIC_FAULT_DET_WARN = 2'h2,
		FN_NONE = 2'h3
	} function_route_t;
endpackage
`default_nettype wire

// File: hdl/glitch_qualifier.sv
// Glitch qualifier: the output follows the input once it has differed for a set count.
// Assumes a synchronous input on the same clock; a limit of zero passes after one cycle.
`include "fault_detect_consts.svh"
`default_nettype none
module glitch_qualifier #(
	parameter int CNT_W = `CNT_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	input wire logic [CNT_W-1:0] lim,
	output var logic dout
);
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic dout_d;

	always_comb begin
		cnt_d = '0;
		dout_d = dout;
		if (din != dout) begin
			// A pulse shorter than the limit restarts the count and never reaches the output.
			if (cnt_q + 1'b1 >= lim) begin
				dout_d = din;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			dout <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			dout <= dout_d;
		end
	end
endmodule
`default_nettype wire

// File: verification/dual_input_fault_detect_assertions.sv
// Port checker for the supervisory input, with a shadow of the registers written on the bus.
// Assumes single word transfers and no read taken in the data phase of a write.
`default_nettype none
module dual_input_fault_detect_assertions (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HRESP,
	input wire logic [7:0] SAMPLE,
	input wire logic FAULT_OUT,
	input wire logic WARNING_OUT,
	input wire logic OVER_LIMIT_FLAG,
	input wire logic UNDER_LIMIT_FLAG,
	input wire logic IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	logic live_q;
	default clocking @(posedge REF_CLK); endclocking
	// Attempts start one edge after release, when the design has really left reset.
	default disable iff (!RST_N || !live_q);
	logic [7:0] sh_q [16];
	logic [7:0] rb_q, orl, url;
	logic [8:0] us;
	logic [3:0] ix_q;
	logic wr_q, take, map;
	assign take = HSEL && HREADY && HTRANS[1];
	assign map = HADDR[31:6] == 26'h3 && HADDR[1:0] == 2'h0 && (!HADDR[5] || HADDR[5:2] == 4'hF);
	function automatic logic [7:0] fld(input logic [3:0] i);
		case (i)
			4'h1, 4'h3, 4'h4, 4'hF: fld = 8'h1F;
			4'h5: fld = 8'h03;
			4'h6: fld = 8'h7F;
			default: fld = 8'hFF;
		endcase
	endfunction
	// Release levels saturate, so a large hysteresis never wraps round.
	always_comb begin
		us = {1'b0, sh_q[2]} + {4'h0, sh_q[3][4:0]};
		url = us[8] ? 8'hFF : us[7:0];
		orl = sh_q[0] > sh_q[1] ? sh_q[0] - sh_q[1] : 8'h00;
	end
	always_ff @(posedge REF_CLK) begin
		rb_q <= sh_q[HADDR[5:2]];
		live_q <= RST_N;
		if (!RST_N) begin
			wr_q <= 1'b0;
			ix_q <= 4'h0;
			sh_q <= '{default: 8'h00};
		end else begin
			wr_q <= take && HWRITE && map;
			if (take)
				ix_q <= HADDR[5:2];
			if (wr_q)
				sh_q[ix_q] <= HWDATA[7:0] & fld(ix_q);
		end
	end
	sequence rd_take;
		take && !HWRITE;
	endsequence
	sequence route_off2;
		sh_q[5][1:0] == 2'h3 ##1 sh_q[5][1:0] == 2'h3;
	endsequence
	sequence no_mask2;
		sh_q[15] == 8'h00 ##1 sh_q[15] == 8'h00;
	endsequence
	hresp_okay_a:
		assert property (HRESP == 1'b0) else $error("response not okay");
	over_set_a:
		assert property (SAMPLE > sh_q[0] |=> OVER_LIMIT_FLAG) else $error("over not set");
	over_release_a:
		assert property (OVER_LIMIT_FLAG && SAMPLE <= orl |=> !OVER_LIMIT_FLAG)
			else $error("over not released");
	under_set_a:
		assert property (SAMPLE < sh_q[2] |=> UNDER_LIMIT_FLAG) else $error("under not set");
	under_release_a:
		assert property (UNDER_LIMIT_FLAG && SAMPLE >= url |=> !UNDER_LIMIT_FLAG)
			else $error("under not released");
	route_off_a:
		assert property (route_off2 |-> !FAULT_OUT && !WARNING_OUT) else $error("route off leaks");
	irq_masked_a:
		assert property (no_mask2 |-> !IRQ) else $error("irq with empty mask");
	unmapped_zero_a:
		assert property (rd_take ##0 !map |=> HRDATA == 32'h0) else $error("unmapped read");
	reg_readback_a:
		assert property (rd_take ##0 (map && HADDR[5:2] != 4'h7 && !wr_q)
			|=> HRDATA == {24'h0, rb_q}) else $error("readback differs");
endmodule
bind dual_input_fault_detect dual_input_fault_detect_assertions i_chk (.REF_CLK(REF_CLK),
	.RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HRESP(HRESP), .SAMPLE(SAMPLE),
	.FAULT_OUT(FAULT_OUT), .WARNING_OUT(WARNING_OUT), .OVER_LIMIT_FLAG(OVER_LIMIT_FLAG),
	.UNDER_LIMIT_FLAG(UNDER_LIMIT_FLAG), .IRQ(IRQ));
`default_nettype wire

// File: verification/supply_rail_model.sv
// Behavioural model of the supervised rail and of the external logic signal.
// Assumes the bench moves target and pin_cmd just after rising edges.
`default_nettype none
module supply_rail_model (
	input wire logic clk,
	input wire logic [7:0] target,
	input wire logic slow,
	input wire logic pin_cmd,
	output var logic [7:0] level,
	output var logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		level = 8'h00;
		pin = 1'b0;
	end
	// A slow rail slews one code per cycle, so thresholds are crossed one step at a time.
	always @(posedge clk) begin
		if (!slow || level == target)
			level <= target;
		else if (level < target)
			level <= level + 8'h01;
		else
			level <= level - 8'h01;
	end
	// The pin moves between clock edges, which exercises the input synchroniser.
	always @(pin_cmd)
		pin <= #3 pin_cmd;
endmodule
`default_nettype wire

// File: verification/tb_dual_input_fault_detect.sv
// Bench for the supervisory input: registers, detector, logic input, routing, interrupt.
// Assumes the rail model drives SAMPLE and LOGIC_PIN and the checker is bound.
`default_nettype none
module tb_dual_input_fault_detect;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SF = 0, SW = 1, SO = 2, SU = 3, SI = 4, SR = 5;
	logic ref_clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, slow = 1'b0, pin_cmd = 1'b0;
	logic hsel = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
	logic [7:0] target = 8'h30;
	wire [31:0] hrdata;
	wire [7:0] level;
	wire hready, pin, fault, warn, over, under, irq;
	int miscompares = 0, checked = 0;
	// Filter code 7 keeps its full length; no scenario waits on it.
	dual_input_fault_detect #(.GF_C5_CYC(20), .GF_C6_CYC(30),
		.PULSE_C1_CYC(50), .PULSE_C2_CYC(100), .PULSE_C3_CYC(200)) i_dut (
		.REF_CLK(ref_clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
		.HREADYOUT(hready), .HRESP(), .SAMPLE(level), .LOGIC_PIN(pin), .FAULT_OUT(fault),
		.WARNING_OUT(warn), .OVER_LIMIT_FLAG(over), .UNDER_LIMIT_FLAG(under), .IRQ(irq));
	supply_rail_model i_rail (.clk(ref_clk), .target(target), .slow(slow),
		.pin_cmd(pin_cmd), .level(level), .pin(pin));
	initial forever #5 ref_clk = ~ref_clk;
	task automatic report_and_stop();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic sig(input int i);
		logic [5:0] v;
		v = {hready, irq, under, over, warn, fault};
		return v[i];
	endfunction
	// Ends at a falling edge, where outputs are settled for the next rising edge.
	task automatic wt(input int i, input logic v, input int lim);
		int n = 0;
		@(negedge ref_clk);
		while (sig(i) !== v && n < lim) begin
			n++;
			@(negedge ref_clk);
		end
		if (sig(i) !== v) begin
			miscompares++;
			report_and_stop();
		end
		chk({31'h0, sig(i)}, {31'h0, v});
	endtask
	task automatic wo(input int i, input logic v, input int lim);
		wt(i, v, lim);
		@(posedge ref_clk);
	endtask
	task automatic hd(input int i, input logic v, input int n);
		repeat (n) begin
			@(negedge ref_clk);
			chk({31'h0, sig(i)}, {31'h0, v});
		end
		@(posedge ref_clk);
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		hsize <= 3'h2;
		haddr <= {22'h0, a, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		wt(SR, 1'b1, 50);
		@(posedge ref_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt(SR, 1'b1, 50);
		q = hrdata;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	// A transfer without select must leave the registers alone.
	task automatic wr_unsel(input logic [7:0] a, input logic [31:0] d);
		haddr <= {22'h0, a, 2'h0};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		@(posedge ref_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(q, e);
	endtask
	task automatic lv(input logic [7:0] x);
		target <= x;
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic drv(input logic det, input logic v);
		if (det)
			target <= v ? 8'h90 : 8'h30;
		else
			pin_cmd <= v;
	endtask
	// A pulse half the filter time must vanish; a steady level must pass.
	task automatic gl(input logic det, input int lim);
		drv(det, 1'b1);
		repeat (lim / 2) @(posedge ref_clk);
		drv(det, 1'b0);
		hd(SF, 1'b0, lim + 10);
		drv(det, 1'b1);
		hd(SF, 1'b0, lim / 2);
		wo(SF, 1'b1, lim + 20);
		drv(det, 1'b0);
		wo(SF, 1'b0, lim + 20);
	endtask
	task automatic s_regs();
		logic [7:0] m [8] = '{8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'h1F, 8'h03, 8'h7F, 8'h1F};
		logic [7:0] a;
		for (int i = 0; i < 8; i++) begin
			a = i == 7 ? 8'h3F : 8'h30 + 8'(i);
			rd(a, 32'h0);
			wr(a, 32'hFFFF_FFFF);
			rd(a, {24'h0, m[i]});
			wr(a, 32'h0);
		end
		wr(8'h38, 32'h5A);
		rd(8'h38, 32'h0);
		wr_unsel(8'h30, 32'hFF);
		rd(8'h30, 32'h0);
	endtask
	task automatic s_over();
		wr(8'h30, 32'h80);
		wr(8'h31, 32'h10);
		lv(8'h81);
		hd(SO, 1'b1, 2);
		hd(SF, 1'b1, 2);
		lv(8'h71);
		hd(SO, 1'b1, 8);
		lv(8'h70);
		hd(SO, 1'b0, 2);
		hd(SF, 1'b0, 2);
	endtask
	task automatic s_under();
		wr(8'h34, 32'h2);
		wr(8'h32, 32'h40);
		wr(8'h33, 32'h5);
		slow <= 1'b1;
		target <= 8'h3F;
		wo(SU, 1'b1, 80);
		wo(SF, 1'b1, 5);
		target <= 8'h44;
		hd(SU, 1'b1, 20);
		target <= 8'h45;
		wo(SU, 1'b0, 10);
		slow <= 1'b0;
	endtask
	task automatic s_types();
		for (int t = 0; t < 4; t++) begin
			wr(8'h34, 32'(t));
			lv(8'h90);
			hd(SF, t < 2, 2);
			lv(8'h30);
			hd(SF, t == 1 || t == 2, 2);
		end
	endtask
	task automatic s_logic();
		int len [4] = '{1000, 50, 100, 200};
		wr(8'h34, 32'h14);
		lv(8'h30);
		gl(1'b1, 20);
		wr(8'h34, 32'h0);
		wr(8'h35, 32'h1);
		pin_cmd <= 1'b1;
		lv(8'h30);
		hd(SF, 1'b1, 2);
		wr(8'h36, 32'h40);
		wo(SF, 1'b0, 10);
		pin_cmd <= 1'b0;
		wo(SF, 1'b1, 10);
		wr(8'h36, 32'h0);
		wo(SF, 1'b0, 10);
		for (int c = 0; c < 4; c++) begin
			wr(8'h36, 32'h20 | 32'(c) << 3);
			pin_cmd <= 1'b1;
			wo(SF, 1'b1, 10);
			hd(SF, 1'b1, len[c] - 10);
			wo(SF, 1'b0, 20);
			pin_cmd <= 1'b0;
			lv(8'h30);
		end
		wr(8'h36, 32'h6);
		gl(1'b0, 30);
	endtask
	task automatic s_route();
		wr(8'h35, 32'h2);
		lv(8'h90);
		hd(SW, 1'b1, 2);
		hd(SF, 1'b0, 2);
		pin_cmd <= 1'b1;
		wo(SF, 1'b1, 50);
		wr(8'h35, 32'h3);
		lv(8'h90);
		hd(SF, 1'b0, 2);
		hd(SW, 1'b0, 2);
		pin_cmd <= 1'b0;
		wr(8'h35, 32'h0);
	endtask
	task automatic s_irq();
		wr(8'h32, 32'h0);
		lv(8'h30);
		bus(8'h37, 1'b0, 32'h0);
		wr(8'h3F, 32'h1);
		lv(8'h90);
		hd(SI, 1'b1, 2);
		rd(8'h37, 32'h0505);
		wo(SI, 1'b0, 5);
		rd(8'h37, 32'h0500);
		wr(8'h3F, 32'h0);
		lv(8'h30);
		lv(8'h90);
		hd(SI, 1'b0, 5);
		wr(8'h3F, 32'h1);
		wo(SI, 1'b1, 5);
		bus(8'h37, 1'b0, 32'h0);
		wo(SI, 1'b0, 5);
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		s_regs();
		s_over();
		s_under();
		s_types();
		s_logic();
		s_route();
		s_irq();
		report_and_stop();
	end
endmodule
`default_nettype wire
